// file: design/rscr_strap_sel.v
// Power-on strap sampling and clock ratio selection with a Wishbone port.
`timescale 1ns/1ns
// Overview of operation
// - Platform code 0,3-6,8-10,12 maps; others reserved
// - Core code 000,011-111 maps; 001,010 reserved
// - Core clock multiplies platform clock, not reference
// - Security strap 0 gives 2:1, 1 gives 3:1
// - Undriven security strap defaults to 3:1
// - During hard reset, configuration pins are inputs
// - On release latch pins, then restore outputs
// - Pull-up on in reset, few clocks after
`include "rscr_regs.vh"

module rscr_strap_sel #(
  parameter NPIN = 8
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Hard reset pin, active low, asynchronous to clk_i.
  input wire hard_reset_n_i,
  // Configuration pins: levels seen at the pads and pad controls.
  input wire [3:0] platform_ratio_straps_i,
  input wire core_ratio_strap_hi_i,
  input wire core_ratio_strap_mid_i,
  input wire core_ratio_strap_lo_i,
  input wire crypto_ratio_strap_i,
  output wire [NPIN-1:0] cfg_pin_o,
  output wire [NPIN-1:0] cfg_pin_oe_o,
  output reg cfg_rx_en_o,
  output reg cfg_pullup_en_o,
  // Normal output function of the shared pins.
  input wire [NPIN-1:0] func_out_i,
  input wire [NPIN-1:0] func_oe_i,
  // Decoded ratios.
  output reg [4:0] plat_ratio_o,
  output reg [3:0] core_ratio_x2_o,
  output reg [6:0] core_ref_ratio_x2_o,
  output reg [1:0] sec_ratio_o,
  output reg plat_rsvd_o,
  output reg core_rsvd_o,
  output reg cfg_done_o,
  // Wishbone classic slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);

  localparam ST_RESET = 2'h0;
  localparam ST_HOLD = 2'h1;
  localparam ST_RUN = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Ratio decode.

  // Returns {reserved, ratio}; a reserved code yields ratio 0.
  function [5:0] plat_dec;
    input [3:0] code;
    begin
      case (code)
        4'h0: plat_dec = 6'h10;
        4'h3: plat_dec = 6'h03;
        4'h4: plat_dec = 6'h04;
        4'h5: plat_dec = 6'h05;
        4'h6: plat_dec = 6'h06;
        4'h8: plat_dec = 6'h08;
        4'h9: plat_dec = 6'h09;
        4'ha: plat_dec = 6'h0a;
        4'hc: plat_dec = 6'h0c;
        default: plat_dec = 6'h20;
      endcase
    end
  endfunction

  // Core ratio in half steps: {reserved, twice the ratio}.
  function [4:0] core_dec;
    input [2:0] code;
    begin
      case (code)
        3'h0: core_dec = 5'h08;
        3'h3: core_dec = 5'h03;
        3'h4: core_dec = 5'h04;
        3'h5: core_dec = 5'h05;
        3'h6: core_dec = 5'h06;
        3'h7: core_dec = 5'h07;
        default: core_dec = 5'h10;
      endcase
    end
  endfunction

  // Core to reference ratio in half steps, saturated to the field width.
  function [6:0] core_mul;
    input [4:0] plat;
    input [3:0] core;
    reg [8:0] prod;
    begin
      prod = plat * core;
      core_mul = prod[8:7] != 2'h0 ? 7'h7f : prod[6:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, a change counts once stages two and
  // three agree.

  wire [NPIN-1:0] pin_raw;
  reg [NPIN-1:0] pin_s1_q;
  reg [NPIN-1:0] pin_s2_q;
  reg [NPIN-1:0] pin_s3_q;
  reg [NPIN-1:0] pin_q;
  reg hr_s1_q;
  reg hr_s2_q;
  reg hr_s3_q;
  reg hr_n_q;

  assign pin_raw = {crypto_ratio_strap_i, core_ratio_strap_hi_i,
                    core_ratio_strap_mid_i, core_ratio_strap_lo_i,
                    platform_ratio_straps_i};

  // Pads reset high so a sampled bit looks pulled up before it settles.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_s1_q <= {NPIN{1'b1}};
      pin_s2_q <= {NPIN{1'b1}};
      pin_s3_q <= {NPIN{1'b1}};
      pin_q <= {NPIN{1'b1}};
      hr_s1_q <= 1'b0;
      hr_s2_q <= 1'b0;
      hr_s3_q <= 1'b0;
      hr_n_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
      hr_s1_q <= hard_reset_n_i;
      hr_s2_q <= hr_s1_q;
      hr_s3_q <= hr_s2_q;
      if (hr_s2_q == hr_s3_q)
        hr_n_q <= hr_s3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling sequence.

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] hold_cnt_q;
  reg [7:0] hold_clks_q;
  reg [NPIN-1:0] strap_q;
  wire [5:0] plat_w;
  wire [4:0] core_w;
  wire hr_rel;

  assign hr_rel = hr_n_q;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET:
        if (hr_rel)
          state_d = ST_HOLD;
      ST_HOLD:
        if (!hr_rel)
          state_d = ST_RESET;
        else if (hold_cnt_q >= hold_clks_q)
          state_d = ST_RUN;
      ST_RUN:
        if (!hr_rel)
          state_d = ST_RESET;
      default:
        state_d = ST_RESET;
    endcase
  end

  assign plat_w = plat_dec(strap_q[`RSCR_SV_PLAT_MSB:`RSCR_SV_PLAT_LSB]);
  assign core_w = core_dec(strap_q[`RSCR_SV_CORE_MSB:`RSCR_SV_CORE_LSB]);

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_RESET;
      hold_cnt_q <= 8'h00;
      strap_q <= {NPIN{1'b1}};
      cfg_rx_en_o <= 1'b1;
      cfg_pullup_en_o <= 1'b1;
      cfg_done_o <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // Straps are captured only on the release edge and then kept.
      if (state_q == ST_RESET && state_d == ST_HOLD)
        strap_q <= pin_q;
      if (state_q == ST_HOLD)
        hold_cnt_q <= hold_cnt_q + 8'h01;
      else
        hold_cnt_q <= 8'h00;
      // Receiver and pull-up go off together after the hold.
      cfg_rx_en_o <= (state_d != ST_RUN);
      cfg_pullup_en_o <= (state_d != ST_RUN);
      cfg_done_o <= (state_d == ST_RUN);
    end
  end

  // Pins stay inputs until the receiver is off, then carry their function.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_pad
      assign cfg_pin_o[gi] = cfg_rx_en_o ? 1'b0 : func_out_i[gi];
      assign cfg_pin_oe_o[gi] = !cfg_rx_en_o && func_oe_i[gi];
    end
  endgenerate

  // Decoded outputs follow the held straps; they change only after a new
  // capture, so consumers see stable ratios for the whole run.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      plat_ratio_o <= `RSCR_PLAT_RST;
      core_ratio_x2_o <= `RSCR_CORE_RST;
      core_ref_ratio_x2_o <= 7'h00;
      sec_ratio_o <= `RSCR_SEC_3TO1;
      plat_rsvd_o <= 1'b0;
      core_rsvd_o <= 1'b0;
    end
    else
    begin
      plat_ratio_o <= plat_w[4:0];
      plat_rsvd_o <= plat_w[5];
      core_ratio_x2_o <= core_w[3:0];
      core_rsvd_o <= core_w[4];
      // Core multiplier is applied to the platform clock.
      core_ref_ratio_x2_o <= core_mul(plat_w[4:0], core_w[3:0]);
      // An undriven strap reads high through the pull-up, giving 3:1.
      sec_ratio_o <= strap_q[`RSCR_SV_SEC_BIT] ?
                     `RSCR_SEC_3TO1 : `RSCR_SEC_2TO1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, unmapped reads return zero.

  wire req;
  wire [31:0] status_w;
  wire [31:0] ratio_w;
  wire [31:0] ctrl_w;
  reg [31:0] rd_d;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  assign status_w = {20'h00000, core_rsvd_o, plat_rsvd_o, cfg_rx_en_o,
                     cfg_done_o, strap_q};
  assign ratio_w = {5'h00, core_ref_ratio_x2_o, 2'h0, sec_ratio_o,
                    4'h0, core_ratio_x2_o, 3'h0, plat_ratio_o};
  assign ctrl_w = {24'h000000, hold_clks_q};

  always @*
  begin
    if (wb_adr_i == `RSCR_STATUS_OFS)
      rd_d = status_w;
    else if (wb_adr_i == `RSCR_RATIO_OFS)
      rd_d = ratio_w;
    else if (wb_adr_i == `RSCR_CTRL_OFS)
      rd_d = ctrl_w;
    else
      rd_d = 32'h00000000;
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      hold_clks_q <= `RSCR_PU_HOLD_CLKS;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= rd_d;
      // Only the low byte lane holds a writable field.
      if (req && wb_we_i && wb_adr_i == `RSCR_CTRL_OFS && wb_sel_i[0])
        hold_clks_q <= wb_dat_i[`RSCR_CT_HOLD_MSB:`RSCR_CT_HOLD_LSB];
    end
  end

endmodule // rscr_strap_sel

// file: design/rscr_regs.vh
// Register map, field positions and reset values of the strap sampler.
`ifndef RSCR_REGS_VH
`define RSCR_REGS_VH

// Register byte offsets (one aligned word each).
`define RSCR_STATUS_OFS 4'h0
`define RSCR_RATIO_OFS 4'h4
`define RSCR_CTRL_OFS 4'h8

// Status fields.
`define RSCR_ST_STRAP_LSB 0
`define RSCR_ST_STRAP_MSB 7
`define RSCR_ST_DONE_BIT 8
`define RSCR_ST_PINREL_BIT 9
`define RSCR_ST_PLAT_RSV_BIT 10
`define RSCR_ST_CORE_RSV_BIT 11

// Ratio fields.
`define RSCR_RT_PLAT_LSB 0
`define RSCR_RT_PLAT_MSB 4
`define RSCR_RT_CORE_LSB 8
`define RSCR_RT_CORE_MSB 11
`define RSCR_RT_SEC_LSB 16
`define RSCR_RT_SEC_MSB 17
`define RSCR_RT_CREF_LSB 20
`define RSCR_RT_CREF_MSB 26

// Control fields.
`define RSCR_CT_HOLD_LSB 0
`define RSCR_CT_HOLD_MSB 7

// Pull-up hold after release, in reference clocks.
`define RSCR_PU_HOLD_CLKS 8'h04

// Strap vector layout: {sec, core hi, core mid, core lo, plat[3:0]}.
`define RSCR_SV_PLAT_LSB 0
`define RSCR_SV_PLAT_MSB 3
`define RSCR_SV_CORE_LSB 4
`define RSCR_SV_CORE_MSB 6
`define RSCR_SV_SEC_BIT 7

// Security ratio codes and reset values of the decoded ratios.
`define RSCR_SEC_2TO1 2'h2
`define RSCR_SEC_3TO1 2'h3
`define RSCR_PLAT_RST 5'h00
`define RSCR_CORE_RST 4'h0

`endif

// file: testbench/rscr_strap_sel_asserts.sv
// Checker of pin handover, ratio decode and bus timing.
`timescale 1ns/1ns
module rscr_chk (
  input wire clk_i, input wire rst_i, input wire hard_reset_n_i,
  input wire [7:0] cfg_pin_o, input wire [7:0] cfg_pin_oe_o,
  input wire [7:0] func_out_i, input wire [7:0] func_oe_i,
  input wire cfg_rx_en_o, input wire cfg_pullup_en_o, input wire cfg_done_o,
  input wire [4:0] plat_ratio_o, input wire [3:0] core_ratio_x2_o,
  input wire [6:0] core_ref_ratio_x2_o, input wire [1:0] sec_ratio_o,
  input wire plat_rsvd_o, input wire core_rsvd_o,
  input wire wb_cyc_i, input wire wb_stb_i, input wire wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [8:0] prod = plat_ratio_o * core_ratio_x2_o;
  property p_in; $fell(hard_reset_n_i) |-> ##[1:6] cfg_rx_en_o; endproperty
  a_in: assert property (p_in) else $error("pins not inputs");
  property p_oe; cfg_rx_en_o |-> cfg_pin_oe_o == 8'h00; endproperty
  a_oe: assert property (p_oe) else $error("pin driven");
  property p_fn;
    !cfg_rx_en_o |-> cfg_pin_o == func_out_i && cfg_pin_oe_o == func_oe_i;
  endproperty
  a_fn: assert property (p_fn) else $error("pin not normal");
  property p_pu; cfg_pullup_en_o == cfg_rx_en_o; endproperty
  a_pu: assert property (p_pu) else $error("pull-up mismatch");
  // The pull-up must be on within the synchroniser delay of hard reset.
  property p_pu_on; !hard_reset_n_i |-> ##[4:5] cfg_pullup_en_o; endproperty
  a_pu_on: assert property (p_pu_on) else $error("no pull-up");
  property p_hold; cfg_done_o && $past(cfg_done_o) |-> $stable(plat_ratio_o)
    && $stable(core_ratio_x2_o) && $stable(sec_ratio_o); endproperty
  a_hold: assert property (p_hold) else $error("ratio moved");
  property p_rsv; cfg_done_o |-> plat_rsvd_o == (plat_ratio_o == 5'h00)
    && core_rsvd_o == (core_ratio_x2_o == 4'h0); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag");
  property p_cref; cfg_done_o |->
    core_ref_ratio_x2_o == (prod > 9'h07f ? 7'h7f : prod[6:0]); endproperty
  a_cref: assert property (p_cref) else $error("core ref ratio");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing");
  c_done: cover property ($rose(cfg_done_o));
  c_rsv: cover property (cfg_done_o && plat_rsvd_o && core_rsvd_o);
  c_sec2: cover property (cfg_done_o && sec_ratio_o == 2'h2);
endmodule // rscr_chk
bind rscr_strap_sel rscr_chk rscr_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
  .hard_reset_n_i(hard_reset_n_i), .cfg_pin_o(cfg_pin_o),
  .cfg_pin_oe_o(cfg_pin_oe_o), .func_out_i(func_out_i),
  .func_oe_i(func_oe_i), .cfg_rx_en_o(cfg_rx_en_o),
  .cfg_pullup_en_o(cfg_pullup_en_o), .cfg_done_o(cfg_done_o),
  .plat_ratio_o(plat_ratio_o), .core_ratio_x2_o(core_ratio_x2_o),
  .core_ref_ratio_x2_o(core_ref_ratio_x2_o), .sec_ratio_o(sec_ratio_o),
  .plat_rsvd_o(plat_rsvd_o), .core_rsvd_o(core_rsvd_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// file: testbench/rscr_board.sv
// Board straps: drivers, floating pins and the on-chip weak pull-up.
`timescale 1ns/1ns
module rscr_board (
  input wire clk_i,
  input wire pullup_en_i,
  input wire [7:0] drv_en_i,
  input wire [7:0] drv_val_i,
  output logic [7:0] pin_o
);
  logic [7:0] last_q = 8'h00;
  // A floating pin toggles so a settled unknown cannot pass for a level.
  always @(posedge clk_i)
    last_q <= pin_o;
  // A driven low beats the weak pull-up; an undriven pin reads high while the pull-up is on and toggles each clock while it is off.
  always_comb
    for (int b = 0; b < 8; b++)
      pin_o[b] = drv_en_i[b] ? drv_val_i[b] :
        (pullup_en_i ? 1'b1 : ~last_q[b]);
endmodule // rscr_board

// file: testbench/tb_reset_strap_clock_ratio_select.sv
// Self-checking bench of strap sampling and ratio decode.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_reset_strap_clock_ratio_select;
  logic clk_i = 0, rst_i = 1, hrn = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] den = 8'hff, dval = 8'h00, fo = 8'h00, foe = 8'h00, pin;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, q, exp_r;
  wire [7:0] po;
  wire [6:0] cref;
  wire [4:0] plat;
  wire [3:0] core;
  wire [1:0] sec;
  wire [31:0] rdat;
  wire pu, done, ack;
  int n_mismatch = 0, total_checks = 0, seed = 25, cr;
  localparam int REF_MHZ = 100;
  logic [3:0] sel = 4'hf;
  logic [7:0] drv, val;
  logic [6:0] ecref;
  logic [1:0] esec;
  logic sb, pci_clk = 0;
  wire [7:0] poe;
  int mem_mhz, pci_edges = 0;
  rscr_board rscr_board_inst (.clk_i(clk_i), .pullup_en_i(pu),
    .drv_en_i(den), .drv_val_i(dval), .pin_o(pin));
  rscr_strap_sel rscr_strap_sel_inst (.clk_i(clk_i), .rst_i(rst_i),
    .hard_reset_n_i(hrn), .platform_ratio_straps_i(pin[3:0]),
    .core_ratio_strap_hi_i(pin[6]), .core_ratio_strap_mid_i(pin[5]),
    .core_ratio_strap_lo_i(pin[4]), .crypto_ratio_strap_i(pin[7]),
    .cfg_pin_o(po), .cfg_pin_oe_o(poe), .cfg_rx_en_o(), .cfg_pullup_en_o(pu),
    .func_out_i(fo), .func_oe_i(foe), .plat_ratio_o(plat),
    .core_ratio_x2_o(core), .core_ref_ratio_x2_o(cref), .sec_ratio_o(sec),
    .plat_rsvd_o(), .core_rsvd_o(), .cfg_done_o(done), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  initial forever #5 clk_i = ~clk_i;
  // The reference runs outside the band that may stand in for the PCI
  // clock, so the board supplies its own, unrelated to clk_i.
  initial forever #17 pci_clk = ~pci_clk;
  always @(posedge pci_clk) pci_edges++;
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i) {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    if (ack !== 1'b1) begin n_mismatch++; give_verdict; end
  endtask
  function logic [4:0] e_plat(input logic [3:0] c);
    case (c)
      4'h0: return 5'h10;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc: return {1'b0, c};
      default: return 5'h00;
    endcase
  endfunction
  function logic [3:0] e_core(input logic [2:0] c);
    return c == 3'h0 ? 4'h8 : (c >= 3'h3 ? {1'b0, c} : 4'h0);
  endfunction
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    wb(1, 4'h8, 32'h6);
    wb(0, 4'h8, 0);
    `CHK(q[7:0], 8'h06)
    // A write without the low byte lane must leave the hold count alone.
    sel <= 4'he;
    wb(1, 4'h8, 32'h9);
    sel <= 4'hf;
    wb(0, 4'h8, 0);
    `CHK(q[7:0], 8'h06)
    wb(0, 4'hc, 0);
    `CHK(q, 32'h0)
    for (int i = 0; i < 16; i++) begin
      mem_mhz = e_plat(i[3:0]) * REF_MHZ;
      drv = {$random(seed) % 2 == 0, 7'h7f};
      val = {$random(seed) % 2 == 0, i[2:0], i[3:0]};
      // Corner cases: a driven 2:1 security strap and an undriven one.
      if (i == 3)
        drv[7] = 1'b1;
      if (i == 3)
        val[7] = 1'b0;
      if (i == 5)
        drv[7] = 1'b0;
      if (mem_mhz == 0 || mem_mhz > 400)
        val[7] = 1'b1;
      @(posedge clk_i) hrn <= 0;
      den <= drv;
      dval <= val;
      {fo, foe} <= 16'($random(seed));
      repeat (8) @(posedge clk_i);
      `CHK(poe, 8'h00)
      `CHK(pu, 1'b1)
      hrn <= 1;
      for (int n = 0; n < 60 && done !== 1'b1; n++) @(posedge clk_i);
      `CHK(done, 1'b1)
      sb = drv[7] ? val[7] : 1'b1;
      esec = sb ? 2'h3 : 2'h2;
      cr = e_plat(i[3:0]) * e_core(i[2:0]);
      ecref = cr > 127 ? 7'h7f : 7'(cr);
      `CHK(plat, e_plat(i[3:0]))
      `CHK(core, e_core(i[2:0]))
      `CHK(cref, ecref)
      `CHK(sec, esec)
      `CHK(po, fo)
      `CHK(poe, foe)
      `CHK(pu, 1'b0)
      wb(1, 4'h4, 32'hffffffff);
      wb(0, 4'h4, 0);
      exp_r = {5'h0, ecref, 2'h0, esec, 4'h0, e_core(i[2:0]), 3'h0,
               e_plat(i[3:0])};
      `CHK(q, exp_r)
      wb(0, 4'h0, 0);
      exp_r = {20'h0, e_core(i[2:0]) == 4'h0, e_plat(i[3:0]) == 5'h00,
               2'b01, sb, val[6:0]};
      `CHK(q, exp_r)
      @(posedge clk_i) {den, dval} <= 16'($random(seed));
      repeat (6) @(posedge clk_i);
      `CHK(plat, e_plat(i[3:0]))
      `CHK(sec, esec)
    end
    `CHK(pci_edges > 0, REF_MHZ < 33 || REF_MHZ > 66)
    // A second reset in mid-run must bring back the reset values.
    @(posedge clk_i) rst_i <= 1;
    repeat (2) @(posedge clk_i);
    `CHK(sec, 2'h3)
    `CHK(plat, 5'h00)
    `CHK(pu, 1'b1)
    rst_i <= 0;
    wb(0, 4'h8, 0);
    `CHK(q[7:0], 8'h04)
    give_verdict;
  end
endmodule // tb_reset_strap_clock_ratio_select
